// ---- hdl/dsc_pkg.sv ----
// Purpose: Shared constants for the display strap and lane routing block
// Assumes: Strap vector and command bit vector share one bit layout
// Notes: Lane map words pack pad indices as {clk, l3, l2, l1, l0}
package dsc_pkg;
    // Strap vector layout
    localparam int STRAP_W = 14;
    localparam int POS_INTERFACE_SELECT_PIN = 0;
    localparam int POS_SWAP = 1;
    localparam int POS_PANEL = 3;
    localparam int POS_PMODE = 4;
    localparam int POS_RES = 6;
    localparam int POS_DEPTH = 9;
    localparam int POS_FMT = 10;
    localparam int POS_LANE_HI = 11;
    localparam int POS_LANE_LO = 12;
    localparam int POS_CMDSEL = 13;
    // Pull-up defaults: MIPI, identity swap, 8-bit VESA, 4 lanes, 3-wire
    localparam logic [STRAP_W-1:0] STRAP_RST = 14'h1e05;
    localparam logic RSTN_RST = 1'b0;

    // Interface select and command port encodings
    localparam logic IF_LVDS = 1'b0;
    localparam logic IF_MIPI = 1'b1;
    localparam logic CMD_3WIRE = 1'b0;
    localparam logic CMD_I2C = 1'b1;

    // Lane map words {clk, l3, l2, l1, l0}, pad order D0,D1,CLK,D2,D3
    localparam int PAD_N = 5;
    localparam logic [14:0] MAP_SWAP00 = {3'h2, 3'h0, 3'h1, 3'h3, 3'h4};
    localparam logic [14:0] MAP_MIPI01 = {3'h2, 3'h0, 3'h4, 3'h3, 3'h1};
    localparam logic [14:0] MAP_IDENT = {3'h2, 3'h4, 3'h3, 3'h1, 3'h0};
    localparam logic [14:0] MAP_MIPI11 = {3'h2, 3'h4, 3'h0, 3'h1, 3'h3};
    localparam logic [14:0] MAP_LVDS01 = {3'h1, 3'h0, 3'h2, 3'h3, 3'h4};
    localparam logic [14:0] MAP_LVDS11 = {3'h3, 3'h4, 3'h2, 3'h1, 3'h0};

    // Panel format
    localparam logic [2:0] RES_CODE_400 = 3'h0;
    localparam logic [8:0] COLS_400 = 9'h190;
    localparam logic [8:0] COLS_480 = 9'h1e0;
    localparam logic [10:0] PANEL_LINES = 11'h500;

    // Lane counts
    localparam logic [2:0] LANES_NONE = 3'h0;
    localparam logic [2:0] LANES_3 = 3'h3;
    localparam logic [2:0] LANES_4 = 3'h4;

    // Link config word {standby, four_lanes, mipi, swap[1:0]}
    localparam int LCFG_W = 5;
    localparam logic [LCFG_W-1:0] LCFG_RST = 5'h0e;

    localparam int PWM_W = 8;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b01,
        HS_WAIT = 2'b10
    } dsc_hs_e;
endpackage

// ---- hdl/dsc_sync2.sv ----
// Purpose: Two-stage level synchroniser, any width
// Assumes: Each bit is a static level or a toggle; words stay stable
// Notes: First stage feeds only the second stage
module dsc_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i, // Destination clock
    input wire logic rst_i, // Async reset, active high
    input wire logic [W-1:0] d_i, // Asynchronous level
    output logic [W-1:0] q_o // Synchronised level
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb begin
        meta_nxt = d_i;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule

// ---- hdl/dsc_pwm_gen.sv ----
// Purpose: Free-running backlight PWM generator
// Assumes: Duty is a stable level from the same clock
// Notes: Full scale duty gives 255 of 256 high; output is registered
module dsc_pwm_gen #(
    parameter int W = 8
) (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Async reset, active high
    input wire logic en_i, // Run the generator
    input wire logic [W-1:0] duty_i, // High time per period
    output logic pwm_o // PWM level
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic pwm_r;
    logic pwm_nxt;

    always_comb begin
        cnt_nxt = en_i ? W'(cnt_r + 1'b1) : '0;
        pwm_nxt = en_i && (cnt_r < duty_i);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            pwm_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    assign pwm_o = pwm_r;
endmodule

// ---- hdl/dsc_strap_top.sv ----
// Purpose: Strap decoding, pin/command merge and lane pad routing
// Assumes: Straps are static while running; pads are sampled on the link clock
// Notes: Config reaches the link domain through a toggle handshake
//
// Behaviour
// - Interface select 0 LVDS, 1 MIPI
// - MIPI swap code maps data pads to lanes
// - MIPI mapping unused in LVDS mode
// - LVDS swap code also moves clock pad
// - LVDS mapping unused in MIPI mode
// - Resolution code 000 gives 400 columns
// - LVDS depth low 6-bit, high 8-bit
// - LVDS 8-bit order low JEIDA, high VESA
// - Reset pin low holds controller in reset
// - LVDS standby while lane-high pin low
// - MIPI lane pins select three or four
// - LVDS self-test while lane-low pin low
// - Command select 0 3-wire, 1 I2C
// - Drive backlight PWM and enable outputs
// - Controller runs when pin AND command bit
// - LVDS standby is pin XOR register bit
// - Every strap except the reset pin is pin XOR command bit
module dsc_strap_top (
    input wire logic clock_i, // System clock, 100 MHz
    input wire logic sys_rst_i, // Async reset, active high
    input wire logic lane_clk_i, // Link clock from the host
    input wire logic [4:0] lane_pad_i, // Pads D0,D1,CLK,D2,D3 on link clock
    input wire logic interface_select_pin_i, // 0 LVDS, 1 MIPI
    input wire logic [1:0] lane_swap_code_i, // Lane swap straps
    input wire logic panel_type_select_i, // Panel type strap
    input wire logic [1:0] power_structure_select_i, // Power structure straps
    input wire logic [2:0] resolution_select_i, // Resolution straps
    input wire logic lvds_depth_select_i, // LVDS 6/8-bit strap
    input wire logic lvds_bit_order_select_i, // LVDS JEIDA/VESA strap
    input wire logic global_reset_n_i, // Global reset pin, active low
    input wire logic lane_count_hi_or_standby_n_i, // Lane count hi / standby_n
    input wire logic lane_count_lo_or_selftest_n_i, // Lane count lo / selftest_n
    input wire logic cmd_select_i, // 0 3-wire, 1 I2C
    input wire logic [13:0] cmd_function_bits_i, // Command function bits
    input wire logic command_reset_bit_i, // Command reset bit
    input wire logic bl_enable_i, // Backlight enable command
    input wire logic [7:0] bl_duty_i, // Backlight duty command
    output logic timing_controller_rst_n_o, // Controller reset, active low
    output logic mode_mipi_o, // Effective interface is MIPI
    output logic [1:0] lane_swap_o, // Effective swap code
    output logic panel_type_o, // Effective panel type
    output logic [1:0] power_mode_o, // Effective power structure
    output logic [2:0] panel_format_code_o, // Effective resolution code
    output logic [8:0] active_columns_o, // RGB columns
    output logic [10:0] active_lines_o, // Lines
    output logic lvds_depth_8bit_o, // LVDS 8-bit input
    output logic lvds_vesa_o, // LVDS VESA order
    output logic lvds_standby_o, // LVDS standby request
    output logic lvds_selftest_o, // LVDS self-test request
    output logic [2:0] mipi_lane_count_o, // MIPI data lanes, 0 in LVDS
    output logic lane_cfg_invalid_o, // Unused MIPI lane code
    output logic cmd_port_i2c_o, // Command port is I2C
    output logic backlight_pwm_out_o, // Backlight PWM
    output logic backlight_enable_out_o, // Backlight enable
    output logic [3:0] lane_data_o, // Logical data lanes, link clock
    output logic lane_clock_pair_o // Logical clock pad sample, link clock
);
    // System domain: strap synchronisation
    logic [dsc_pkg::STRAP_W-1:0] strap_raw;
    logic [dsc_pkg::STRAP_W-1:0] strap_q;
    logic rstn_q;
    logic [dsc_pkg::STRAP_W-1:0] eff;

    assign strap_raw = {cmd_select_i, lane_count_lo_or_selftest_n_i,
        lane_count_hi_or_standby_n_i, lvds_bit_order_select_i,
        lvds_depth_select_i, resolution_select_i, power_structure_select_i,
        panel_type_select_i, lane_swap_code_i, interface_select_pin_i};

    dsc_sync2 #(.W(dsc_pkg::STRAP_W), .RST_VAL(dsc_pkg::STRAP_RST)) u_strap_sync (
        .clk_i(clock_i),
        .rst_i(sys_rst_i),
        .d_i(strap_raw),
        .q_o(strap_q)
    );

    dsc_sync2 #(.W(1), .RST_VAL(dsc_pkg::RSTN_RST)) u_rstn_sync (
        .clk_i(clock_i),
        .rst_i(sys_rst_i),
        .d_i(global_reset_n_i),
        .q_o(rstn_q)
    );

    // Pin and command merge
    assign eff = strap_q ^ cmd_function_bits_i;

    logic is_mipi;
    logic lane_hi;
    logic lane_lo;
    assign is_mipi = (eff[dsc_pkg::POS_INTERFACE_SELECT_PIN] == dsc_pkg::IF_MIPI);
    assign lane_hi = eff[dsc_pkg::POS_LANE_HI];
    assign lane_lo = eff[dsc_pkg::POS_LANE_LO];

    // Decoded configuration registers
    logic timing_controller_rstn_r, timing_controller_rstn_nxt;
    logic mipi_r, mipi_nxt;
    logic [1:0] swap_r, swap_nxt;
    logic panel_r, panel_nxt;
    logic [1:0] pmode_r, pmode_nxt;
    logic [2:0] res_r, res_nxt;
    logic [8:0] cols_r, cols_nxt;
    logic [10:0] lines_r, lines_nxt;
    logic depth_r, depth_nxt;
    logic vesa_r, vesa_nxt;
    logic stby_r, stby_nxt;
    logic bist_r, bist_nxt;
    logic [2:0] lanes_r, lanes_nxt;
    logic inval_r, inval_nxt;
    logic i2c_r, i2c_nxt;
    logic bl_en_r, bl_en_nxt;

    always_comb begin
        timing_controller_rstn_nxt = rstn_q & command_reset_bit_i;
        mipi_nxt = is_mipi;
        swap_nxt = eff[dsc_pkg::POS_SWAP +: 2];
        panel_nxt = eff[dsc_pkg::POS_PANEL];
        pmode_nxt = eff[dsc_pkg::POS_PMODE +: 2];
        res_nxt = eff[dsc_pkg::POS_RES +: 3];
        // Only code 000 is the narrow panel; all others take 480
        cols_nxt = (res_nxt == dsc_pkg::RES_CODE_400) ? dsc_pkg::COLS_400 : dsc_pkg::COLS_480;
        lines_nxt = dsc_pkg::PANEL_LINES;
        // In MIPI the LVDS-only pins read as their defaults
        depth_nxt = is_mipi ? 1'b1 : eff[dsc_pkg::POS_DEPTH];
        vesa_nxt = (is_mipi || !eff[dsc_pkg::POS_DEPTH]) ? 1'b1 : eff[dsc_pkg::POS_FMT];
        stby_nxt = !is_mipi && !lane_hi;
        bist_nxt = !is_mipi && !lane_lo;
        lanes_nxt = dsc_pkg::LANES_NONE;
        inval_nxt = 1'b0;
        if (is_mipi) begin
            if (lane_hi) begin
                lanes_nxt = lane_lo ? dsc_pkg::LANES_4 : dsc_pkg::LANES_3;
            end else begin
                lanes_nxt = dsc_pkg::LANES_4;
                inval_nxt = 1'b1;
            end
        end
        i2c_nxt = (eff[dsc_pkg::POS_CMDSEL] == dsc_pkg::CMD_I2C);
        bl_en_nxt = bl_enable_i && timing_controller_rstn_r && !stby_r;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            timing_controller_rstn_r <= 1'b0;
            mipi_r <= dsc_pkg::STRAP_RST[dsc_pkg::POS_INTERFACE_SELECT_PIN];
            swap_r <= dsc_pkg::STRAP_RST[dsc_pkg::POS_SWAP +: 2];
            panel_r <= dsc_pkg::STRAP_RST[dsc_pkg::POS_PANEL];
            pmode_r <= dsc_pkg::STRAP_RST[dsc_pkg::POS_PMODE +: 2];
            res_r <= dsc_pkg::STRAP_RST[dsc_pkg::POS_RES +: 3];
            cols_r <= dsc_pkg::COLS_400;
            lines_r <= dsc_pkg::PANEL_LINES;
            depth_r <= 1'b1;
            vesa_r <= 1'b1;
            stby_r <= 1'b0;
            bist_r <= 1'b0;
            lanes_r <= dsc_pkg::LANES_4;
            inval_r <= 1'b0;
            i2c_r <= dsc_pkg::CMD_3WIRE;
            bl_en_r <= 1'b0;
        end else begin
            timing_controller_rstn_r <= timing_controller_rstn_nxt;
            mipi_r <= mipi_nxt;
            swap_r <= swap_nxt;
            panel_r <= panel_nxt;
            pmode_r <= pmode_nxt;
            res_r <= res_nxt;
            cols_r <= cols_nxt;
            lines_r <= lines_nxt;
            depth_r <= depth_nxt;
            vesa_r <= vesa_nxt;
            stby_r <= stby_nxt;
            bist_r <= bist_nxt;
            lanes_r <= lanes_nxt;
            inval_r <= inval_nxt;
            i2c_r <= i2c_nxt;
            bl_en_r <= bl_en_nxt;
        end
    end

    // Backlight, gated off while controller held or in standby
    dsc_pwm_gen #(.W(dsc_pkg::PWM_W)) u_pwm (
        .clk_i(clock_i),
        .rst_i(sys_rst_i),
        .en_i(bl_en_r),
        .duty_i(bl_duty_i),
        .pwm_o(backlight_pwm_out_o)
    );

    // Config handshake toward the link domain
    logic [dsc_pkg::LCFG_W-1:0] cfg_word;
    logic [dsc_pkg::LCFG_W-1:0] sent_r, sent_nxt;
    logic req_r, req_nxt;
    logic ack_q;
    dsc_pkg::dsc_hs_e hs_r, hs_nxt;
    logic lnk_seen_r, lnk_seen_nxt;

    assign cfg_word = {stby_r, (lanes_r == dsc_pkg::LANES_4), mipi_r, swap_r};

    dsc_sync2 #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
        .clk_i(clock_i),
        .rst_i(sys_rst_i),
        .d_i(lnk_seen_r),
        .q_o(ack_q)
    );

    always_comb begin
        hs_nxt = hs_r;
        sent_nxt = sent_r;
        req_nxt = req_r;
        case (hs_r)
            dsc_pkg::HS_IDLE: begin
                // Word is held steady until the link side acknowledges
                if (cfg_word != sent_r) begin
                    sent_nxt = cfg_word;
                    req_nxt = !req_r;
                    hs_nxt = dsc_pkg::HS_WAIT;
                end
            end
            dsc_pkg::HS_WAIT: begin
                if (ack_q == req_r) begin
                    hs_nxt = dsc_pkg::HS_IDLE;
                end
            end
            default: begin
                hs_nxt = dsc_pkg::HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hs_r <= dsc_pkg::HS_IDLE;
            sent_r <= dsc_pkg::LCFG_RST;
            req_r <= 1'b0;
        end else begin
            hs_r <= hs_nxt;
            sent_r <= sent_nxt;
            req_r <= req_nxt;
        end
    end

    // Link domain: reset release synchronised to the link clock
    logic lnk_rstn_q;
    logic lnk_rst;
    logic lnk_req_q;
    logic [dsc_pkg::LCFG_W-1:0] lnk_cfg_r, lnk_cfg_nxt;
    logic [4:0] pad_r, pad_nxt;
    logic [3:0] ldata_r, ldata_nxt;
    logic lclk_r, lclk_nxt;
    logic [14:0] map;

    dsc_sync2 #(.W(1), .RST_VAL(1'b0)) u_lnk_rst (
        .clk_i(lane_clk_i),
        .rst_i(sys_rst_i),
        .d_i(1'b1),
        .q_o(lnk_rstn_q)
    );
    assign lnk_rst = !lnk_rstn_q;

    dsc_sync2 #(.W(1), .RST_VAL(1'b0)) u_req_sync (
        .clk_i(lane_clk_i),
        .rst_i(lnk_rst),
        .d_i(req_r),
        .q_o(lnk_req_q)
    );

    // Swap code read through the table of the active interface only
    always_comb begin
        case ({lnk_cfg_r[2], lnk_cfg_r[1:0]})
            {dsc_pkg::IF_MIPI, 2'h0}: map = dsc_pkg::MAP_SWAP00;
            {dsc_pkg::IF_MIPI, 2'h1}: map = dsc_pkg::MAP_MIPI01;
            {dsc_pkg::IF_MIPI, 2'h2}: map = dsc_pkg::MAP_IDENT;
            {dsc_pkg::IF_MIPI, 2'h3}: map = dsc_pkg::MAP_MIPI11;
            {dsc_pkg::IF_LVDS, 2'h0}: map = dsc_pkg::MAP_SWAP00;
            {dsc_pkg::IF_LVDS, 2'h1}: map = dsc_pkg::MAP_LVDS01;
            {dsc_pkg::IF_LVDS, 2'h3}: map = dsc_pkg::MAP_LVDS11;
            default: map = dsc_pkg::MAP_IDENT;
        endcase
    end

    always_comb begin
        lnk_seen_nxt = lnk_req_q;
        lnk_cfg_nxt = lnk_cfg_r;
        if (lnk_req_q != lnk_seen_r) begin
            lnk_cfg_nxt = sent_r;
        end
        pad_nxt = lane_pad_i;
        for (int k = 0; k < 4; k++) begin
            ldata_nxt[k] = pad_r[map[3*k +: 3]];
        end
        lclk_nxt = pad_r[map[12 +: 3]];
        // Lane 3 idles in three-lane MIPI
        if (lnk_cfg_r[2] && !lnk_cfg_r[3]) begin
            ldata_nxt[3] = 1'b0;
        end
        // Lanes idle during LVDS standby
        if (lnk_cfg_r[4]) begin
            ldata_nxt = 4'h0;
        end
    end

    always_ff @(posedge lane_clk_i or posedge lnk_rst) begin
        if (lnk_rst) begin
            lnk_seen_r <= 1'b0;
            lnk_cfg_r <= dsc_pkg::LCFG_RST;
            pad_r <= 5'h00;
            ldata_r <= 4'h0;
            lclk_r <= 1'b0;
        end else begin
            lnk_seen_r <= lnk_seen_nxt;
            lnk_cfg_r <= lnk_cfg_nxt;
            pad_r <= pad_nxt;
            ldata_r <= ldata_nxt;
            lclk_r <= lclk_nxt;
        end
    end

    assign timing_controller_rst_n_o = timing_controller_rstn_r;
    assign mode_mipi_o = mipi_r;
    assign lane_swap_o = swap_r;
    assign panel_type_o = panel_r;
    assign power_mode_o = pmode_r;
    assign panel_format_code_o = res_r;
    assign active_columns_o = cols_r;
    assign active_lines_o = lines_r;
    assign lvds_depth_8bit_o = depth_r;
    assign lvds_vesa_o = vesa_r;
    assign lvds_standby_o = stby_r;
    assign lvds_selftest_o = bist_r;
    assign mipi_lane_count_o = lanes_r;
    assign lane_cfg_invalid_o = inval_r;
    assign cmd_port_i2c_o = i2c_r;
    assign backlight_enable_out_o = bl_en_r;
    assign lane_data_o = ldata_r;
    assign lane_clock_pair_o = lclk_r;
endmodule

// ---- verif/dsc_strap_props.sv ----
// Purpose: Assertions on strap decode and backlight outputs
// Assumes: Pins held steady between resets
// Notes: Strap decode checks wait until the pin history has settled
module dsc_strap_props (
    input wire logic clock_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic interface_select_pin_i, // Strap
    input wire logic [1:0] lane_swap_code_i, // Strap
    input wire logic [2:0] resolution_select_i, // Strap
    input wire logic lvds_depth_select_i, // Strap
    input wire logic lvds_bit_order_select_i, // Strap
    input wire logic global_reset_n_i, // Strap
    input wire logic lane_count_hi_or_standby_n_i, // Strap
    input wire logic lane_count_lo_or_selftest_n_i, // Strap
    input wire logic cmd_select_i, // Strap
    input wire logic [13:0] cmd_function_bits_i, // Command
    input wire logic command_reset_bit_i, // Command
    input wire logic bl_enable_i, // Command
    input wire logic [7:0] bl_duty_i, // Command
    input wire logic timing_controller_rst_n_o, // Out
    input wire logic mode_mipi_o, // Out
    input wire logic [1:0] lane_swap_o, // Out
    input wire logic [2:0] panel_format_code_o, // Out
    input wire logic [8:0] active_columns_o, // Out
    input wire logic [10:0] active_lines_o, // Out
    input wire logic lvds_depth_8bit_o, // Out
    input wire logic lvds_vesa_o, // Out
    input wire logic lvds_standby_o, // Out
    input wire logic lvds_selftest_o, // Out
    input wire logic [2:0] mipi_lane_count_o, // Out
    input wire logic lane_cfg_invalid_o, // Out
    input wire logic cmd_port_i2c_o, // Out
    input wire logic backlight_pwm_out_o, // Out
    input wire logic backlight_enable_out_o // Out
);
    logic [14:0] pin_w, d1_r, d2_r, d3_r, d4_r;
    logic [13:0] cmd_r, eff_w;
    logic crst_r, settled_w;
    logic [2:0] cyc_r;
    // Panel and power pins are not watched here
    assign pin_w = {global_reset_n_i, cmd_select_i, lane_count_lo_or_selftest_n_i, lane_count_hi_or_standby_n_i,
        lvds_bit_order_select_i, lvds_depth_select_i, resolution_select_i, 3'h0, lane_swap_code_i,
        interface_select_pin_i};
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cyc_r <= 3'h0;
        end else if (cyc_r != 3'h7) begin
            cyc_r <= cyc_r + 3'h1;
        end
    end
    always_ff @(posedge clock_i) begin
        d1_r <= pin_w;
        d2_r <= d1_r;
        d3_r <= d2_r;
        d4_r <= d3_r;
        cmd_r <= cmd_function_bits_i;
        crst_r <= command_reset_bit_i;
    end
    // Outputs lag pins by three edges
    assign settled_w = cyc_r == 3'h7 && d1_r == d2_r && d2_r == d3_r && d3_r == d4_r;
    assign eff_w = d1_r[13:0] ^ cmd_r;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_ctl_down;
        (!timing_controller_rst_n_o || lvds_standby_o) ##1 (!timing_controller_rst_n_o || lvds_standby_o);
    endsequence
    sequence s_bl_idle;
        (!backlight_enable_out_o || bl_duty_i == 8'h00) [*3];
    endsequence
    chk_timing_controller_and: assert property (settled_w |-> timing_controller_rst_n_o == (d1_r[14] & crst_r))
        else $error("controller reset is not pin and bit");
    chk_field_xor: assert property (settled_w |-> mode_mipi_o == eff_w[0] && lane_swap_o == eff_w[2:1]
        && panel_format_code_o == eff_w[8:6] && cmd_port_i2c_o == eff_w[13])
        else $error("effective field is not pin xor command");
    chk_lane_count: assert property (settled_w && eff_w[0] |-> lane_cfg_invalid_o == !eff_w[11]
        && mipi_lane_count_o == ((eff_w[11] && !eff_w[12]) ? 3'h3 : 3'h4))
        else $error("lane count wrong");
    chk_lvds_flags: assert property (settled_w && !eff_w[0] |-> lvds_standby_o == !eff_w[11]
        && lvds_selftest_o == !eff_w[12] && lvds_depth_8bit_o == eff_w[9] && mipi_lane_count_o == 3'h0)
        else $error("lvds flags wrong");
    chk_lvds_order: assert property (settled_w && !eff_w[0] && eff_w[9] |-> lvds_vesa_o == eff_w[10])
        else $error("lvds bit order wrong");
    chk_mipi_masks: assert property (mode_mipi_o |-> lvds_depth_8bit_o && lvds_vesa_o
        && !lvds_standby_o && !lvds_selftest_o)
        else $error("lvds control active in mipi mode");
    chk_panel_size: assert property (active_lines_o == 11'h500
        && active_columns_o == ((panel_format_code_o == 3'h0) ? 9'h190 : 9'h1e0))
        else $error("panel size wrong");
    chk_bl_follow: assert property (!bl_enable_i |=> !backlight_enable_out_o)
        else $error("backlight on without command");
    chk_bl_gated: assert property (s_ctl_down |-> !backlight_enable_out_o)
        else $error("backlight on in reset or standby");
    chk_pwm_quiet: assert property (s_bl_idle |=> !backlight_pwm_out_o)
        else $error("pwm high while off");
endmodule

bind dsc_strap_top dsc_strap_props i_props (.*);

// ---- verif/dsc_host_model.sv ----
// Purpose: Host end of the video link: link clock and pad levels
// Assumes: Pads launch just after a rising link clock edge
// Notes: Clock stands still between frames
module dsc_host_model (
    input wire logic frame_i, // Frame active
    input wire logic [4:0] pattern_i, // Next pad levels
    output logic lane_clk_o, // Link clock
    output logic [4:0] pad_o // Pads D0,D1,CLK,D2,D3
);
    timeunit 1ns;
    timeprecision 100ps;
    // Video only; commands never share the link with the side port
    initial begin
        lane_clk_o = 1'b0;
        pad_o = 5'h15;
        #3;
        forever begin
            #7.5;
            lane_clk_o = frame_i ? ~lane_clk_o : 1'b0;
        end
    end
    always @(posedge lane_clk_o) begin
        pad_o <= pattern_i;
    end
    // Released pads show the inverse
    always @(negedge frame_i) begin
        pad_o <= ~pad_o;
    end
endmodule

// ---- verif/testbench.sv ----
// Purpose: Strap decode, lane routing and backlight tests
// Assumes: Straps change only inside reset
// Notes: Lane maps are probed with one-hot pad patterns
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i, sys_rst_i, lane_clk_i, frame, command_reset_bit_i, bl_enable_i;
    logic interface_select_pin_i, panel_type_select_i, lvds_depth_select_i, lvds_bit_order_select_i;
    logic global_reset_n_i, lane_count_hi_or_standby_n_i, lane_count_lo_or_selftest_n_i, cmd_select_i;
    logic [1:0] lane_swap_code_i, power_structure_select_i, lane_swap_o, power_mode_o;
    logic [2:0] resolution_select_i, panel_format_code_o, mipi_lane_count_o;
    logic [4:0] lane_pad_i, pattern;
    logic [7:0] bl_duty_i;
    logic [13:0] cmd_function_bits_i;
    logic [14:0] pins;
    logic timing_controller_rst_n_o, mode_mipi_o, panel_type_o, lvds_depth_8bit_o, lvds_vesa_o;
    logic lvds_standby_o, lvds_selftest_o, lane_cfg_invalid_o, cmd_port_i2c_o;
    logic backlight_pwm_out_o, backlight_enable_out_o, lane_clock_pair_o;
    logic [8:0] active_columns_o;
    logic [10:0] active_lines_o;
    logic [3:0] lane_data_o;
    int fail_count, check_count, hi;
    // {clk,l3,l2,l1,l0} pad index per {mode, swap}
    localparam logic [14:0] MAP_T [8] = '{15'h205c, 15'h109c, 15'h28c8, 15'h3888,
        15'h205c, 15'h2119, 15'h28c8, 15'h280b};
    assign {global_reset_n_i, cmd_select_i, lane_count_lo_or_selftest_n_i, lane_count_hi_or_standby_n_i,
        lvds_bit_order_select_i, lvds_depth_select_i, resolution_select_i, power_structure_select_i,
        panel_type_select_i, lane_swap_code_i, interface_select_pin_i} = pins;
    dsc_host_model i_host (.frame_i(frame), .pattern_i(pattern), .lane_clk_o(lane_clk_i), .pad_o(lane_pad_i));
    dsc_strap_top i_dut (.*);
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic restrap(input logic [14:0] v);
        @(negedge clock_i);
        sys_rst_i = 1'b1;
        frame = 1'b1;
        cmd_function_bits_i = 14'h0;
        pins = v;
        repeat (6) @(negedge clock_i);
        sys_rst_i = 1'b0;
        repeat (10) @(negedge clock_i);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    function automatic logic [4:0] exp_map(input int m, input int k);
        for (int i = 0; i < 5; i++) begin
            exp_map[i] = MAP_T[m][3*i +: 3] == 3'(k);
        end
    endfunction
    initial begin
        #50us;
        fail_count++;
        end_of_test();
    end
    initial begin
        fail_count = 0;
        check_count = 0;
        sys_rst_i = 1'b1;
        pattern = 5'h0;
        command_reset_bit_i = 1'b1;
        bl_enable_i = 1'b0;
        bl_duty_i = 8'h0;
        restrap(15'h5e05);
        check(16'({mode_mipi_o, lane_swap_o, mipi_lane_count_o, lvds_depth_8bit_o, lvds_vesa_o, cmd_port_i2c_o,
            timing_controller_rst_n_o, active_columns_o == 9'h190}), 16'h069b);
        $display("defaults test done");
        for (int i = 0; i < 4; i++) begin
            command_reset_bit_i = i[0];
            restrap({i[1], 14'h1e05});
            check(16'(timing_controller_rst_n_o), 16'(i == 3));
        end
        command_reset_bit_i = 1'b1;
        $display("controller reset test done");
        for (int m = 0; m < 8; m++) begin
            restrap(15'h5e00 | {12'h0, 2'(m), m[2]});
            for (int k = 0; k < 5; k++) begin
                pattern = 5'h01 << k;
                wait_cyc(6);
                check(16'({lane_clock_pair_o, lane_data_o}), 16'(exp_map(m, k)));
            end
            frame = 1'b0;
        end
        $display("lane map test done");
        restrap(15'h4e05);
        pattern = 5'h10;
        wait_cyc(6);
        check(16'({mipi_lane_count_o, lane_data_o[3], lane_cfg_invalid_o}), 16'h000c);
        restrap(15'h5605);
        check(16'({mipi_lane_count_o, lane_cfg_invalid_o}), 16'h0009);
        restrap(15'h5805);
        check(16'({lvds_depth_8bit_o, lvds_vesa_o, lvds_standby_o, lvds_selftest_o}), 16'h000c);
        restrap(15'h4004);
        pattern = 5'h1f;
        wait_cyc(6);
        check(16'({lvds_standby_o, lvds_selftest_o, lvds_depth_8bit_o, lvds_vesa_o, mipi_lane_count_o,
            lane_data_o}), 16'h0680);
        cmd_function_bits_i = 14'h0a00;
        wait_cyc(2);
        check(16'({lvds_standby_o, lvds_depth_8bit_o, lvds_vesa_o}), 16'h0002);
        $display("lane count and lvds test done");
        for (int r = 0; r < 8; r++) begin
            cmd_function_bits_i = {r[0], 4'h0, r[2:0], r[1:0], r[2], 3'h0};
            wait_cyc(2);
            check({panel_format_code_o, power_mode_o, panel_type_o, cmd_port_i2c_o, active_columns_o},
                {r[2:0], r[1:0], r[2], r[0], (r == 0) ? 9'h190 : 9'h1e0});
        end
        cmd_function_bits_i = 14'h0001;
        wait_cyc(2);
        check(16'(mode_mipi_o), 16'h0001);
        $display("command merge test done");
        restrap(15'h5e05);
        bl_duty_i = 8'h40;
        bl_enable_i = 1'b1;
        wait_cyc(4);
        hi = 0;
        repeat (256) begin
            @(negedge clock_i);
            hi += int'(backlight_pwm_out_o === 1'b1);
        end
        check(16'(hi), 16'h0040);
        check(16'(backlight_enable_out_o), 16'h0001);
        bl_enable_i = 1'b0;
        wait_cyc(4);
        check(16'({backlight_enable_out_o, backlight_pwm_out_o}), 16'h0000);
        $display("backlight test done");
        end_of_test();
    end
endmodule
